// ---- logic/pbsb_pkg.sv ----
// Shared constants and types of the processor system bus block
`default_nettype none
package pbsb_pkg;
   // ****************************************
   // Bus widths and counts
   // ****************************************
   localparam int AD_W = 32;
   localparam int CMD_W = 9;
   localparam int BLK_WORDS = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int MODE_BITS = 256;
   localparam int MODE_DIV = 256;
   localparam int CLK_MHZ = 20;
   // ****************************************
   // Command identifier encodings
   // ****************************************
   localparam int CMD_DATA_BIT = 8;
   localparam logic [CMD_W-1:0] CMD_TYPE_MASK = 9'h1C0;
   localparam logic [CMD_W-1:0] CMD_READ = 9'h000;
   localparam logic [CMD_W-1:0] CMD_WRITE = 9'h040;
   localparam logic [CMD_W-1:0] CMD_NULL = 9'h0C0;
   localparam logic [CMD_W-1:0] CMD_BLOCK = 9'h008;
   localparam logic [CMD_W-1:0] DATA_IDENT_MID = 9'h100;
   localparam logic [CMD_W-1:0] DATA_IDENT_LAST = 9'h180;
   // ****************************************
   // Mode stream fields and reset values
   // ****************************************
   localparam int MODE_WB_LO = 1;
   localparam int MODE_WB_HI = 4;
   localparam int MODE_TMR_OFF = 11;
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [8:0] BITCNT_RST = 9'h000;
   localparam logic [7:0] DIV_SAMPLE = 8'h7F;
   localparam logic [2:0] CNT3_RST = 3'h0;
   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic write;
      logic block;
      logic [2:0] size_m1;
      logic [AD_W-1:0] addr;
   } pbsb_req_t;
   typedef struct packed {
      logic last;
      logic [AD_W-1:0] data;
   } pbsb_word_t;
   typedef struct packed {
      logic [AD_W-1:0] ad;
      logic [CMD_W-1:0] cmd;
   } pbsb_bus_t;
endpackage
`default_nettype wire

// ---- logic/pbsb_fifo.sv ----
// Write data FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pbsb_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("DEPTH must be a power of two");
   end
   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign out_valid = wp_r != rp_r;
   assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_data = mem_r[rp_r[AW-1:0]];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (push) mem_r[wp_r[AW-1:0]] <= in_data;
   end
endmodule // pbsb_fifo
`default_nettype wire

// ---- logic/pbsb_mode_rx.sv ----
// Boot-time serial mode stream reader
`timescale 1ns/1ps
`default_nettype none
module pbsb_mode_rx (
   input wire logic clk,
   input wire logic rst,
   input wire logic power_good,
   input wire logic cfg_serial_in,
   output logic cfg_serial_clock,
   output logic [pbsb_pkg::MODE_BITS-1:0] cfg_mode,
   output logic cfg_done
);
   logic [7:0] div_r;
   logic [8:0] bit_r;
   logic run_r;
   logic done_r;
   logic [pbsb_pkg::MODE_BITS-1:0] mode_r;
   wire sample = run_r && !done_r && div_r == pbsb_pkg::DIV_SAMPLE;
   // Free running divided clock
   assign cfg_serial_clock = div_r[7]; // RQ11 RQ13
   assign cfg_mode = mode_r;
   assign cfg_done = done_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_r <= pbsb_pkg::DIV_RST;
         bit_r <= pbsb_pkg::BITCNT_RST;
         run_r <= 1'b0;
         done_r <= 1'b0;
         mode_r <= '0;
      end else begin
         div_r <= div_r + 8'h01;
         if (power_good) run_r <= 1'b1; // RQ12 RQ14
         if (sample) begin
            mode_r[bit_r[7:0]] <= cfg_serial_in; // RQ23
            bit_r <= bit_r + 9'h001;
            if (bit_r == 9'(pbsb_pkg::MODE_BITS - 1)) done_r <= 1'b1; // RQ12
         end
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   property p_mode_clk_period;
      @(posedge clk) disable iff (rst)
      $rose(cfg_serial_clock) |-> ##256 $rose(cfg_serial_clock);
   endproperty
   a_mode_clk_period: assert property (p_mode_clk_period) else $error("mode clock period"); // RQ11
   property p_mode_frozen;
      @(posedge clk) disable iff (rst)
      done_r |=> $stable(mode_r) && done_r;
   endproperty
   a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed after done"); // RQ13
   c_mode_done: cover property (@(posedge clk) disable iff (rst) $rose(done_r));
endmodule // pbsb_mode_rx
`default_nettype wire

// ---- logic/pbsb_sys_if.sv ----
// Processor system bus interface with boot mode reader and standby control
// Operation
// RQ1: Supports single 1-8 byte transfers and 8-word block transfers.
// RQ2: Low three address bits are byte address; command gives byte count.
// RQ3: Read/write accept inputs sampled before the address is removed.
// RQ4: Only read responses and null requests are accepted from the agent.
// RQ5: External request input answered by a release pulse, bus to slave.
// RQ6: Valid output asserted whenever processor drives command or data; in write idle cycles ad_oe stays on with proc_drive_valid_n high.
// RQ7: Agent valid only while agent owns and drives the buses.
// RQ8: One processor request outstanding at a time.
// RQ9: Read start drives valid, address and read command together.
// RQ10: Accepted read tristates drivers and pulses release; agent returns data.
// RQ11: Mode clock output is the bus clock divided by 256.
// RQ12: After power good, 256 mode bits are read serially.
// RQ13: After the stream, mode clock keeps running, input ignored.
// RQ14: Source presents bit 0 at power good, then up to bit 255.
// RQ15: Wait instruction enables interrupts and requests standby.
// RQ16: Wait with idle bus stops internal clocks.
// RQ17: Clock, timer, interrupt, request and reset logic stay active.
// RQ18: Wait with busy bus acts as no-operation.
// RQ19: Any interrupt, timer included, leaves standby; the code ignores the timer while mode bit 11 (MODE_TMR_OFF) is set.
// RQ20: Block write: write command, data words, last marked end-of-data.
// RQ21: Command bus marks address or data and type on every valid cycle.
// RQ22: Mode field sets words per group and idle cycles between groups.
// RQ23: One mode bit per mode clock, first bit stored at position zero.
`timescale 1ns/1ps
`default_nettype none
module pbsb_sys_if #(
   parameter int FIFO_DEPTH = pbsb_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire pbsb_pkg::pbsb_req_t req,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [pbsb_pkg::AD_W-1:0] wr_data,
   output logic rd_valid,
   output pbsb_pkg::pbsb_word_t rd_word,
   output logic agent_unsup,
   input wire logic [pbsb_pkg::AD_W-1:0] ad_in,
   output logic [pbsb_pkg::AD_W-1:0] ad_out,
   output logic ad_oe,
   input wire logic [pbsb_pkg::CMD_W-1:0] cmd_in,
   output logic [pbsb_pkg::CMD_W-1:0] cmd_out,
   output logic cmd_oe,
   output logic proc_drive_valid_n,
   input wire logic agent_drive_valid_n,
   input wire logic read_accept_n,
   input wire logic write_accept_n,
   input wire logic ext_bus_request_n,
   output logic bus_release_n,
   input wire logic power_good,
   input wire logic cfg_serial_in,
   output logic cfg_serial_clock,
   output logic [pbsb_pkg::MODE_BITS-1:0] cfg_mode,
   output logic cfg_done,
   input wire logic wait_exec,
   input wire logic [5:0] irq_n,
   input wire logic nmi_n,
   input wire logic timer_irq,
   output logic standby,
   output logic core_clk_en,
   output logic int_enable,
   output logic wait_nop
);
   if (FIFO_DEPTH < pbsb_pkg::BLK_WORDS) begin : g_chk
      $error("FIFO_DEPTH below block size");
   end
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WDATA, ST_WGAP, ST_SLAVE} pbsb_st_t;
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [pbsb_pkg::CMD_W-1:0] req_cmd(input pbsb_pkg::pbsb_req_t r);
      logic [pbsb_pkg::CMD_W-1:0] c;
      c = r.write ? pbsb_pkg::CMD_WRITE : pbsb_pkg::CMD_READ;
      if (r.block) c = c | pbsb_pkg::CMD_BLOCK;
      else c = c | {6'h00, r.size_m1};
      return c;
   endfunction
   // Words per group and idle cycles after a group
   function automatic logic [5:0] wb_pattern(input logic [3:0] code);
      logic [5:0] p;
      unique case (code)
         4'h0: p = {3'h1, 3'h0};
         4'h1: p = {3'h2, 3'h1};
         4'h2: p = {3'h2, 3'h2};
         4'h3: p = {3'h1, 3'h1};
         4'h4: p = {3'h2, 3'h3};
         4'h5: p = {3'h2, 3'h4};
         4'h6: p = {3'h1, 3'h2};
         4'h7: p = {3'h2, 3'h5};
         4'h8: p = {3'h1, 3'h2};
         default: p = {3'h1, 3'h0};
      endcase
      return p;
   endfunction
   // ****************************************
   // Mode reader and data FIFO
   // ****************************************
   pbsb_mode_rx u_mode (
      .clk(clk),
      .rst(rst),
      .power_good(power_good),
      .cfg_serial_in(cfg_serial_in),
      .cfg_serial_clock(cfg_serial_clock),
      .cfg_mode(cfg_mode),
      .cfg_done(cfg_done)
   );
   logic fifo_valid;
   logic fifo_pop;
   logic [pbsb_pkg::AD_W-1:0] fifo_data;
   pbsb_fifo #(.W(pbsb_pkg::AD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );
   // ****************************************
   // Bus state
   // ****************************************
   pbsb_st_t st_r, st_nxt;
   pbsb_pkg::pbsb_req_t req_r;
   pbsb_pkg::pbsb_bus_t bus_r, bus_nxt;
   logic oe_r, oe_nxt;
   logic pval_n_r, pval_n_nxt;
   logic rel_n_r, rel_n_nxt;
   logic [2:0] words_r, words_nxt;
   logic [2:0] grp_r, grp_nxt;
   logic [2:0] gap_r, gap_nxt;
   logic rd_valid_r;
   pbsb_pkg::pbsb_word_t rd_word_r;
   logic unsup_r;
   logic [5:0] pat;
   wire [2:0] grp_words = pat[5:3];
   wire [2:0] grp_gap = pat[2:0];
   assign pat = wb_pattern(cfg_mode[pbsb_pkg::MODE_WB_HI:pbsb_pkg::MODE_WB_LO]); // RQ22
   wire bus_idle = st_r == ST_IDLE;
   wire take_req = req_valid && req_ready;
   wire accept = req_r.write ? !write_accept_n : !read_accept_n;
   wire last_word = !req_r.block || words_r == 3'(pbsb_pkg::BLK_WORDS - 1);
   wire agent_word = st_r == ST_SLAVE && !agent_drive_valid_n;
   wire agent_data = agent_word && cmd_in[pbsb_pkg::CMD_DATA_BIT];
   wire agent_last = agent_data && cmd_in == pbsb_pkg::DATA_IDENT_LAST;
   wire agent_null = agent_word && cmd_in == pbsb_pkg::CMD_NULL;
   wire agent_bad = agent_word && !agent_data && !agent_null;
   assign req_ready = bus_idle && ext_bus_request_n; // RQ8
   assign fifo_pop = st_r == ST_WDATA && fifo_valid;
   always_comb begin
      st_nxt = st_r;
      bus_nxt = bus_r;
      oe_nxt = oe_r;
      pval_n_nxt = 1'b1;
      rel_n_nxt = 1'b1;
      words_nxt = words_r;
      grp_nxt = grp_r;
      gap_nxt = gap_r;
      unique case (st_r)
         ST_IDLE: begin
            oe_nxt = 1'b0;
            if (!ext_bus_request_n) begin
               st_nxt = ST_SLAVE; // RQ5
               rel_n_nxt = 1'b0;
            end else if (take_req) begin
               st_nxt = ST_ADDR; // RQ9 RQ2 RQ21
               bus_nxt = '{ad: req.addr, cmd: req_cmd(req)};
               oe_nxt = 1'b1;
               pval_n_nxt = 1'b0; // RQ6
            end
         end
         ST_ADDR: begin
            if (accept && !req_r.write) begin
               st_nxt = ST_SLAVE; // RQ10
               oe_nxt = 1'b0;
               rel_n_nxt = 1'b0;
            end else if (accept) begin
               st_nxt = ST_WDATA; // RQ20
               words_nxt = pbsb_pkg::CNT3_RST;
               grp_nxt = pbsb_pkg::CNT3_RST;
            end else begin
               pval_n_nxt = 1'b0; // RQ3
            end
         end
         ST_WDATA: begin
            if (fifo_valid) begin
               bus_nxt.ad = fifo_data; // RQ1
               bus_nxt.cmd = last_word ? pbsb_pkg::DATA_IDENT_LAST
                                       : pbsb_pkg::DATA_IDENT_MID; // RQ20 RQ21
               pval_n_nxt = 1'b0; // RQ6
               words_nxt = words_r + 3'h1;
               grp_nxt = grp_r + 3'h1;
               if (last_word) begin
                  st_nxt = ST_IDLE; // RQ8
               end else if (grp_r + 3'h1 == grp_words) begin
                  grp_nxt = pbsb_pkg::CNT3_RST;
                  gap_nxt = grp_gap;
                  if (grp_gap != 3'h0) st_nxt = ST_WGAP; // RQ22
               end
            end
         end
         ST_WGAP: begin
            gap_nxt = gap_r - 3'h1;
            if (gap_r == 3'h1) st_nxt = ST_WDATA;
         end
         ST_SLAVE: begin
            if (agent_last || agent_null) st_nxt = ST_IDLE; // RQ4
         end
         default: st_nxt = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         req_r <= '0;
         bus_r <= '0;
         oe_r <= 1'b0;
         pval_n_r <= 1'b1;
         rel_n_r <= 1'b1;
         words_r <= pbsb_pkg::CNT3_RST;
         grp_r <= pbsb_pkg::CNT3_RST;
         gap_r <= pbsb_pkg::CNT3_RST;
      end else begin
         st_r <= st_nxt;
         if (take_req && ext_bus_request_n) req_r <= req;
         bus_r <= bus_nxt;
         oe_r <= oe_nxt;
         pval_n_r <= pval_n_nxt;
         rel_n_r <= rel_n_nxt;
         words_r <= words_nxt;
         grp_r <= grp_nxt;
         gap_r <= gap_nxt;
      end
   end
   // Response capture while in slave state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_valid_r <= 1'b0;
         rd_word_r <= '0;
         unsup_r <= 1'b0;
      end else begin
         rd_valid_r <= agent_data; // RQ7 RQ10
         rd_word_r <= '{last: agent_last, data: ad_in};
         unsup_r <= agent_bad; // RQ4
      end
   end
   assign ad_out = bus_r.ad;
   assign cmd_out = bus_r.cmd;
   assign ad_oe = oe_r;
   assign cmd_oe = oe_r;
   assign proc_drive_valid_n = pval_n_r;
   assign bus_release_n = rel_n_r;
   assign rd_valid = rd_valid_r;
   assign rd_word = rd_word_r;
   assign agent_unsup = unsup_r;
   // ****************************************
   // Standby control
   // ****************************************
   logic stby_r;
   logic int_en_r;
   logic nop_r;
   wire tmr_wake = timer_irq && !cfg_mode[pbsb_pkg::MODE_TMR_OFF];
   wire wake = !(&irq_n) || !nmi_n || tmr_wake; // RQ17
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stby_r <= 1'b0;
         int_en_r <= 1'b0;
         nop_r <= 1'b0;
      end else begin
         nop_r <= wait_exec && !bus_idle; // RQ18
         if (wait_exec) int_en_r <= 1'b1; // RQ15
         if (stby_r && wake) stby_r <= 1'b0; // RQ19
         else if (wait_exec && bus_idle) stby_r <= 1'b1; // RQ16
      end
   end
   assign standby = stby_r;
   assign core_clk_en = !stby_r; // RQ16
   assign int_enable = int_en_r;
   assign wait_nop = nop_r;
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_valid_drives;
      !proc_drive_valid_n |-> ad_oe && cmd_oe;
   endproperty
   a_valid_drives: assert property (p_valid_drives) else $error("valid without drive"); // RQ6
   property p_read_issue;
      take_req && !req.write |=> !proc_drive_valid_n &&
         (cmd_out & pbsb_pkg::CMD_TYPE_MASK) == pbsb_pkg::CMD_READ && ad_out == $past(req.addr);
   endproperty
   a_read_issue: assert property (p_read_issue) else $error("read issue wrong"); // RQ9
   property p_read_release;
      st_r == ST_ADDR && !req_r.write && !read_accept_n |=>
         !bus_release_n && !ad_oe ##1 bus_release_n;
   endproperty
   a_read_release: assert property (p_read_release) else $error("no release after read"); // RQ10
   property p_one_req;
      st_r != ST_IDLE |-> !req_ready ##1 $stable(req_r);
   endproperty
   a_one_req: assert property (p_one_req) else $error("second request taken"); // RQ8
   property p_ext_release;
      st_r == ST_IDLE && !ext_bus_request_n |=> !bus_release_n && st_r == ST_SLAVE;
   endproperty
   a_ext_release: assert property (p_ext_release) else $error("ext request not released"); // RQ5
   property p_addr_hold;
      st_r == ST_ADDR && !accept |=> st_r == ST_ADDR && $stable(ad_out) && ad_oe;
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address dropped early"); // RQ3
   property p_block_last;
      fifo_pop && req_r.block && words_r == 3'h7 |=>
         cmd_out == pbsb_pkg::DATA_IDENT_LAST && !proc_drive_valid_n && st_r == ST_IDLE;
   endproperty
   a_block_last: assert property (p_block_last) else $error("block end not marked"); // RQ20
   property p_wait_nop;
      wait_exec && !bus_idle && !stby_r |=> !stby_r && wait_nop;
   endproperty
   a_wait_nop: assert property (p_wait_nop) else $error("busy wait entered standby"); // RQ18
   property p_wake;
      stby_r && wake |=> !stby_r && core_clk_en;
   endproperty
   a_wake: assert property (p_wake) else $error("interrupt did not wake"); // RQ19
   property p_enter;
      wait_exec && bus_idle && !stby_r |=> stby_r && !core_clk_en && int_enable;
   endproperty
   a_enter: assert property (p_enter) else $error("idle wait missed standby"); // RQ16
   c_read_done: cover property (st_r == ST_SLAVE && agent_last);
   c_block_write: cover property (fifo_pop && req_r.block && words_r == 3'h7);
   c_standby: cover property (stby_r ##1 !stby_r);
   c_ext_null: cover property (st_r == ST_SLAVE && agent_null);
endmodule // pbsb_sys_if
`default_nettype wire

// ---- sim/pbsb_agent_model.sv ----
// External agent model facing the processor system bus
`timescale 1ns/1ps
`default_nettype none
module pbsb_agent_model (
   input wire logic clk,
   input wire logic [pbsb_pkg::AD_W-1:0] bus_ad,
   input wire logic [pbsb_pkg::CMD_W-1:0] bus_cmd,
   input wire logic proc_drive_valid_n,
   input wire logic bus_release_n,
   input wire logic [3:0] dly,
   input wire logic bad,
   output logic [pbsb_pkg::AD_W-1:0] p_ad,
   output logic [pbsb_pkg::CMD_W-1:0] p_cmd,
   output logic agent_drive_valid_n,
   output logic read_accept_n,
   output logic write_accept_n
);
   // ********
   // Accept, response and release
   // ********
   logic [pbsb_pkg::CMD_W-1:0] typ;
   logic [pbsb_pkg::AD_W-1:0] base;
   logic [3:0] cnt, left, k;
   logic [1:0] ph;
   logic rd_pend, skip, sent;
   assign typ = bus_cmd & pbsb_pkg::CMD_TYPE_MASK;
   initial begin
      {cnt, left, k, ph, rd_pend, skip, sent, base, p_ad, p_cmd} = '0;
      {agent_drive_valid_n, read_accept_n, write_accept_n} = 3'h7;
   end
   always @(negedge clk) begin
      if (!proc_drive_valid_n && !bus_cmd[pbsb_pkg::CMD_DATA_BIT]) begin
         if (cnt >= dly) begin
            read_accept_n <= typ != pbsb_pkg::CMD_READ;
            write_accept_n <= typ != pbsb_pkg::CMD_WRITE;
            if (typ == pbsb_pkg::CMD_READ) begin
               rd_pend <= 1'h1;
               base <= bus_ad;
               left <= ((bus_cmd & pbsb_pkg::CMD_BLOCK) != 0) ? 4'h8 : 4'h1;
            end
         end else begin
            cnt <= cnt + 4'h1;
         end
      end else begin
         cnt <= 4'h0;
         read_accept_n <= 1'h1;
         write_accept_n <= 1'h1;
      end
      if (!bus_release_n) ph <= 2'h1;
      else if (ph == 2'h1) ph <= 2'h2;
      if (ph == 2'h2 && !skip) begin
         agent_drive_valid_n <= 1'h0;
         skip <= dly != 4'h0;
         if (rd_pend) begin
            p_ad <= base + {28'h0, k};
            p_cmd <= (k == left - 4'h1) ? pbsb_pkg::DATA_IDENT_LAST : pbsb_pkg::DATA_IDENT_MID;
            k <= k + 4'h1;
            if (k == left - 4'h1) begin
               {ph, rd_pend, k} <= '0;
            end
         end else if (bad && !sent) begin
            p_cmd <= pbsb_pkg::CMD_WRITE;
            sent <= 1'h1;
         end else begin
            p_cmd <= pbsb_pkg::CMD_NULL;
            ph <= 2'h0;
            sent <= 1'h0;
         end
      end else begin
         agent_drive_valid_n <= 1'h1;
         skip <= 1'h0;
         p_ad <= ~p_ad;
         p_cmd <= ~p_cmd;
      end
   end
endmodule // pbsb_agent_model
`default_nettype wire

// ---- sim/tb_pbsb_sys_if.sv ----
// Self-checking bench of the processor system bus block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_pbsb_sys_if;
   // ********
   // Signals and instances
   // ********
   localparam logic [255:0] MODE_VAL = 256'h1006;
   localparam int TMO = 90000;
   logic clk, rst, req_valid, req_ready, wr_valid, wr_ready, rd_valid, agent_unsup;
   logic ad_oe, cmd_oe, proc_drive_valid_n, agent_drive_valid_n, read_accept_n;
   logic write_accept_n, ext_bus_request_n, bus_release_n, power_good, cfg_serial_in;
   logic cfg_serial_clock, cfg_done, wait_exec, nmi_n, timer_irq, standby, core_clk_en;
   logic int_enable, wait_nop, bad, seen_unsup;
   logic [5:0] irq_n;
   logic [3:0] dly;
   logic [pbsb_pkg::AD_W-1:0] wr_data, ad_out, ad_w, p_ad, wbase;
   logic [pbsb_pkg::CMD_W-1:0] cmd_out, cmd_w, p_cmd;
   logic [pbsb_pkg::MODE_BITS-1:0] cfg_mode;
   pbsb_pkg::pbsb_req_t req;
   pbsb_pkg::pbsb_word_t rd_word;
   int error_cnt, checked, cyc;
   assign ad_w = ad_oe ? ad_out : p_ad;
   assign cmd_w = cmd_oe ? cmd_out : p_cmd;
   pbsb_sys_if DUT (.clk, .rst, .req_valid, .req_ready, .req, .wr_valid, .wr_ready, .wr_data,
      .rd_valid, .rd_word, .agent_unsup, .ad_in(ad_w), .ad_out, .ad_oe, .cmd_in(cmd_w),
      .cmd_out, .cmd_oe, .proc_drive_valid_n, .agent_drive_valid_n, .read_accept_n,
      .write_accept_n, .ext_bus_request_n, .bus_release_n, .power_good, .cfg_serial_in,
      .cfg_serial_clock, .cfg_mode, .cfg_done, .wait_exec, .irq_n, .nmi_n, .timer_irq,
      .standby, .core_clk_en, .int_enable, .wait_nop);
   pbsb_agent_model agent (.clk, .bus_ad(ad_w), .bus_cmd(cmd_w), .proc_drive_valid_n,
      .bus_release_n, .dly, .bad, .p_ad, .p_cmd, .agent_drive_valid_n, .read_accept_n,
      .write_accept_n);
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (agent_unsup === 1'h1) seen_unsup <= 1'h1;
      if (cyc == TMO) begin
         error_cnt++;
         end_sim();
      end
   end
   // ********
   // Scenario tasks
   // ********
   task automatic end_sim();
      if (error_cnt == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic push(input int n);
      for (int i = 0; i < n; i++) begin
         `CHK("wr_ready", 1'h1, wr_ready)
         wr_valid = 1'h1;
         wr_data = wbase + i;
         @(negedge clk);
      end
      wr_valid = 1'h0;
      if (n == pbsb_pkg::BLK_WORDS) `CHK("fifo_full", 1'h0, wr_ready)
   endtask
   task automatic xfer(input logic w, input logic b, input logic [2:0] sz,
         input logic [31:0] a, input int gap);
      int n, k, c;
      logic [8:0] ec;
      n = b ? pbsb_pkg::BLK_WORDS : 1;
      ec = w ? pbsb_pkg::CMD_WRITE : pbsb_pkg::CMD_READ;
      ec = ec | (b ? pbsb_pkg::CMD_BLOCK : {6'h00, sz});
      req = '{write: w, block: b, size_m1: sz, addr: a};
      req_valid = 1'h1;
      @(negedge clk);
      req_valid = 1'h0;
      `CHK("addr", a, ad_out)
      `CHK("cmd", ec, cmd_out)
      `CHK("valid", 1'h0, proc_drive_valid_n)
      `CHK("oe", 1'h1, ad_oe)
      `CHK("busy", 1'h0, req_ready)
      c = 0;
      while (proc_drive_valid_n === 1'h0 && c < 20) begin
         c++;
         @(negedge clk);
      end
      `CHK("stand", dly + 1, c)
      if (!w) begin
         `CHK("release", 1'h0, bus_release_n)
         `CHK("tristate", 1'h0, ad_oe)
      end
      for (k = 0; k < n; k++) begin
         c = 0;
         while ((w ? proc_drive_valid_n : ~rd_valid) !== 1'h0 && c < 40) begin
            c++;
            @(negedge clk);
         end
         ec = (k == n - 1) ? pbsb_pkg::DATA_IDENT_LAST : pbsb_pkg::DATA_IDENT_MID;
         if (w) begin
            `CHK("wdata", wbase + k, ad_out)
            `CHK("ident", ec, cmd_out)
            if (k > 0) `CHK("gap", gap, c)
         end else begin
            `CHK("rdata", a + k, rd_word.data)
            `CHK("last", k == n - 1, rd_word.last)
         end
         @(negedge clk);
      end
      repeat (2) @(negedge clk);
      `CHK("idle", 1'h1, req_ready)
      `CHK("oe_off", 1'h0, ad_oe)
   endtask
   task automatic t_ext(input logic bd);
      int c;
      bad = bd;
      seen_unsup = 1'h0;
      ext_bus_request_n = 1'h0;
      @(negedge clk);
      `CHK("ext_ready", 1'h0, req_ready)
      for (c = 0; c < 10 && bus_release_n !== 1'h0; c++) @(negedge clk);
      `CHK("ext_rel", 1'h0, bus_release_n)
      `CHK("ext_oe", 1'h0, ad_oe)
      ext_bus_request_n = 1'h1;
      for (c = 0; c < 20 && req_ready !== 1'h1; c++) @(negedge clk);
      @(negedge clk);
      `CHK("ext_done", 1'h1, req_ready)
      `CHK("unsup", bd, seen_unsup)
      bad = 1'h0;
   endtask
   task automatic t_stby();
      for (int i = 0; i < 8; i++) begin
         wait_exec = 1'h1;
         @(negedge clk);
         wait_exec = 1'h0;
         `CHK("standby", 1'h1, standby)
         `CHK("clk_off", 1'h0, core_clk_en)
         `CHK("int_en", 1'h1, int_enable)
         if (i == 0) t_ext(1'h0);
         if (i < 6) irq_n[i] = 1'h0;
         else if (i == 6) nmi_n = 1'h0;
         else timer_irq = 1'h1;
         @(negedge clk);
         `CHK("wake", 1'h0, standby)
         `CHK("clk_on", 1'h1, core_clk_en)
         {irq_n, nmi_n, timer_irq} = 8'hFE;
         @(negedge clk);
      end
      dly = 4'h6;
      fork
         xfer(1'h0, 1'h0, 3'h3, 32'h00006000, 0);
         begin
            repeat (3) @(negedge clk);
            wait_exec = 1'h1;
            @(negedge clk);
            wait_exec = 1'h0;
            `CHK("nop", 1'h1, wait_nop)
            `CHK("no_stby", 1'h0, standby)
         end
      join
   endtask
   task automatic wait_fall(output int n);
      n = 0;
      while (cfg_serial_clock !== 1'h1 && n < 600) begin
         n++;
         @(negedge clk);
      end
      while (cfg_serial_clock !== 1'h0 && n < 600) begin
         n++;
         @(negedge clk);
      end
   endtask
   task automatic t_mode();
      int n;
      wait_fall(n);
      power_good = 1'h1;
      cfg_serial_in = MODE_VAL[0];
      for (int i = 1; i < 256; i++) begin
         wait_fall(n);
         if (i == 2) `CHK("mode_clk", 256, n)
         cfg_serial_in = MODE_VAL[i];
      end
      wait_fall(n);
      `CHK("cfg_done", 1'h1, cfg_done)
      `CHK("cfg_mode", MODE_VAL, cfg_mode)
      for (int i = 0; i < 2; i++) begin
         cfg_serial_in = ~cfg_serial_in;
         wait_fall(n);
      end
      `CHK("clk_runs", 256, n)
      `CHK("frozen", MODE_VAL, cfg_mode)
   endtask
   // ********
   // Main sequence
   // ********
   initial begin
      {rst, irq_n, nmi_n} = 8'hFF;
      {req_valid, wr_valid, power_good, cfg_serial_in, wait_exec, timer_irq, bad} = '0;
      {ext_bus_request_n, seen_unsup, req, wr_data, dly, wbase} = '0;
      ext_bus_request_n = 1'h1;
      {error_cnt, checked, cyc} = '0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      `CHK("rst_oe", 1'h0, ad_oe)
      for (int i = 0; i < 8; i++) begin
         dly = i[3:0];
         xfer(1'h0, 1'h0, i[2:0], 32'h12340000 + i, 0);
      end
      dly = 4'h2;
      xfer(1'h0, 1'h1, 3'h0, 32'h00008000, 0);
      wbase = 32'hC0DE0000;
      push(1);
      dly = 4'h0;
      xfer(1'h1, 1'h0, 3'h7, 32'h00002000, 0);
      wbase = 32'h5A5A0000;
      push(8);
      dly = 4'h4;
      xfer(1'h1, 1'h1, 3'h0, 32'h00003000, 0);
      t_ext(1'h1);
      t_ext(1'h0);
      t_stby();
      t_mode();
      wbase = 32'h00770000;
      push(8);
      dly = 4'h1;
      xfer(1'h1, 1'h1, 3'h0, 32'h00004000, 1);
      end_sim();
   end
endmodule // tb_pbsb_sys_if
`default_nettype wire
